/* verilog/rtb_timer.sv */
// rtb_timer: 8-bit reload timer with event input, output pin and irq
// assumes an avalon-mm master on CLK_SYS and a synchronous low reset
// Overview of operation
// - count up per tick, overflow reloads or wraps
// - overflow sets sticky flag, cleared by software
// - event mode counts falling edges of pin
// - low three mode bits choose prescaler tap, code 7 selects event input
// - mode register write-only, reset zero, bit3 reload
// - mode writes settle two cycles after previous
// - two-bit output mode register, read-write, reset zero
// - nonzero output mode claims pin, level resets low
// - toggle mode inverts output on overflow
// - force-low mode drives output low on overflow
// - force-high mode drives output high on overflow
// - reload nibbles write-only, low resets zero
// - low write holds, high write loads counter
// - high write alone loads written nibble over stored low nibble
// - high read latches low nibble for later read
// - pin function register four bits, reset zero
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module rtb_timer (
    input  wire logic        CLK_SYS,
    input  wire logic        RSTN,
    input  wire logic [7:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    input  wire logic        EVENT_INPUT_PIN,
    output logic             TIMER_OUTPUT_PIN,
    output logic             TIMER_OUTPUT_SEL,
    output logic [3:0]       PIN_FUNCTION,
    output logic             IRQ
);
    logic                  ack_reg;
    logic [31:0]           rdata_reg;
    logic [7:0]            count_reg;
    logic [7:0]            count_next;
    logic [3:0]            lat_lo_reg;
    logic [3:0]            rl_lo_reg;
    logic [3:0]            rl_hi_reg;
    rtb_pkg::rtb_mode_s    mode_reg;
    rtb_pkg::rtb_mode_s    pend_reg;
    logic [1:0]            settle_reg;
    logic [1:0]            omode_reg;
    logic [3:0]            pinfn_reg;
    logic                  out_reg;
    logic                  out_next;
    logic                  flag_reg;
    logic                  mask_reg;

    logic                  acc;
    logic [5:0]            idx;
    logic                  wr;
    logic                  rd;
    logic [3:0]            wnib;
    logic                  wr_mode;
    logic                  wr_lo;
    logic                  wr_hi;
    logic                  wr_omode;
    logic                  wr_pinfn;
    logic                  wr_stat;
    logic                  wr_mask;
    logic                  rd_hi;
    logic                  presc_tick;
    logic                  ev_fall;
    logic                  ev_tick;
    logic                  tick;
    logic                  ovf;
    logic [7:0]            reload_val;
    logic [31:0]           rdata_sel;

    // bus decode: every access gets exactly one wait cycle
    assign acc      = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign idx      = AVS_ADDRESS[7:2];
    assign wr       = acc & AVS_WRITE & AVS_BYTEENABLE[0];
    assign rd       = acc & AVS_READ;
    assign wnib     = AVS_WRITEDATA[3:0];
    assign wr_mode  = wr & (idx == rtb_pkg::IDX_MODE_ONE);
    assign wr_lo    = wr & (idx == rtb_pkg::IDX_RELOAD_LO);
    assign wr_hi    = wr & (idx == rtb_pkg::IDX_RELOAD_HI);
    assign wr_omode = wr & (idx == rtb_pkg::IDX_OUT_MODE);
    assign wr_pinfn = wr & (idx == rtb_pkg::IDX_PIN_FN);
    assign wr_stat  = wr & (idx == rtb_pkg::IDX_IRQ_STATUS);
    assign wr_mask  = wr & (idx == rtb_pkg::IDX_IRQ_MASK);
    assign rd_hi    = rd & (idx == rtb_pkg::IDX_RELOAD_HI);

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_reg;
    assign AVS_READDATA    = rdata_reg;

    // mode and pin function registers read as zero, as do unmapped words; the high reload word reads the counter, the low one its latch
    assign rdata_sel =
        (idx == rtb_pkg::IDX_RELOAD_HI)  ? {28'h0000000, count_reg[7:4]} :
        (idx == rtb_pkg::IDX_RELOAD_LO)  ? {28'h0000000, lat_lo_reg} :
        (idx == rtb_pkg::IDX_OUT_MODE)   ? {30'h0000000, omode_reg} :
        (idx == rtb_pkg::IDX_IRQ_STATUS) ? {31'h0000000, flag_reg} :
        (idx == rtb_pkg::IDX_IRQ_MASK)   ? {31'h0000000, mask_reg} :
        32'h00000000;

    rtb_prescale u_presc (
        .clk_sys (CLK_SYS),
        .rstn    (RSTN),
        .clk_sel (mode_reg.clk_sel),
        .tick    (presc_tick)
    );

    rtb_fall_det u_evdet (
        .clk_sys (CLK_SYS),
        .rstn    (RSTN),
        .pin     (EVENT_INPUT_PIN),
        .fall    (ev_fall)
    );

    // event edges count only once the pin is handed to the timer
    assign ev_tick = ev_fall & pinfn_reg[rtb_pkg::POS_EV_PIN];
    assign tick    = (mode_reg.clk_sel == rtb_pkg::CSEL_EXT) ? ev_tick
                   : presc_tick;
    assign ovf     = tick & (count_reg == rtb_pkg::CNT_TOP);
    assign reload_val = {rl_hi_reg, rl_lo_reg};

    // a software load wins over a coinciding tick
    always_comb begin
        count_next = count_reg;
        if (wr_hi) begin
            count_next = {wnib, rl_lo_reg};
        end else if (ovf) begin
            count_next = mode_reg.reload ? reload_val
                       : rtb_pkg::CNT_WRAP;
        end else if (tick) begin
            count_next = count_reg + 8'h01;
        end
    end

    // force modes are one-shot; software must pick the opposite level
    always_comb begin
        out_next = out_reg;
        if (ovf) begin
            case (omode_reg)
                rtb_pkg::OMODE_TOGGLE: out_next = ~out_reg;
                rtb_pkg::OMODE_LOW:    out_next = 1'b0;
                rtb_pkg::OMODE_HIGH:   out_next = 1'b1;
                default:               out_next = out_reg;
            endcase
        end
    end

    assign TIMER_OUTPUT_PIN = out_reg;
    assign TIMER_OUTPUT_SEL = (omode_reg != rtb_pkg::OMODE_PORT);
    assign PIN_FUNCTION     = pinfn_reg;
    assign IRQ              = flag_reg & mask_reg;

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg   <= acc;
            rdata_reg <= rd ? rdata_sel : rdata_reg;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            count_reg  <= rtb_pkg::RST_COUNT;
            lat_lo_reg <= 4'h0;
            out_reg    <= 1'b0;
        end else begin
            count_reg  <= count_next;
            lat_lo_reg <= rd_hi ? count_reg[3:0] : lat_lo_reg;
            out_reg    <= out_next;
        end
    end

    // a new mode waits in pend_reg until the settle count runs out
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            mode_reg   <= rtb_pkg::RST_MODE_ONE;
            pend_reg   <= rtb_pkg::RST_MODE_ONE;
            settle_reg <= 2'h0;
        end else if (wr_mode) begin
            pend_reg   <= wnib;
            settle_reg <= rtb_pkg::MODE_SETTLE_CYC;
        end else if (settle_reg != 2'h0) begin
            settle_reg <= settle_reg - 2'h1;
            mode_reg   <= (settle_reg == 2'h1) ? pend_reg : mode_reg;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            rl_lo_reg <= rtb_pkg::RST_RELOAD_LO;
            omode_reg <= rtb_pkg::RST_OUT_MODE;
            pinfn_reg <= rtb_pkg::RST_PIN_FN;
            mask_reg  <= 1'b0;
        end else begin
            rl_lo_reg <= wr_lo ? wnib : rl_lo_reg;
            omode_reg <= wr_omode ? wnib[1:0] : omode_reg;
            pinfn_reg <= wr_pinfn ? wnib : pinfn_reg;
            mask_reg  <= wr_mask ? wnib[0] : mask_reg;
        end
    end

    // upper reload nibble has no reset; software must write it before any reload
    always_ff @(posedge CLK_SYS) begin
        rl_hi_reg <= wr_hi ? wnib : rl_hi_reg;
    end

    // an overflow in the clearing cycle keeps the flag set
    always_ff @(posedge CLK_SYS) begin
        if (!RSTN) begin
            flag_reg <= 1'b0;
        end else if (ovf) begin
            flag_reg <= 1'b1;
        end else if (wr_stat && wnib[rtb_pkg::POS_OVF_FLAG]) begin
            flag_reg <= 1'b0;
        end
    end

    sequence s_mode_wr;
        wr_mode;
    endsequence

    sequence s_quiet2;
        !wr_mode ##1 !wr_mode;
    endsequence

    property p_inc;
        @(posedge CLK_SYS) disable iff (!RSTN)
        tick && !ovf && !wr_hi |=> count_reg == $past(count_reg) + 8'h01;
    endproperty
    a_inc: assert property (p_inc) else $error("count did not step");

    property p_wrap;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf && !mode_reg.reload && !wr_hi |=> count_reg == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap) else $error("free mode did not wrap");

    property p_reload;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf && mode_reg.reload && !wr_hi |=> count_reg == $past(reload_val);
    endproperty
    a_reload: assert property (p_reload) else $error("reload value lost");

    property p_flag;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf |=> flag_reg ##0 (IRQ == mask_reg);
    endproperty
    a_flag: assert property (p_flag) else $error("overflow flag not set");

    property p_ev_gate;
        @(posedge CLK_SYS) disable iff (!RSTN)
        mode_reg.clk_sel == 3'h7 && !pinfn_reg[0] |-> !tick;
    endproperty
    a_ev_gate: assert property (p_ev_gate) else $error("event counted on port pin");

    property p_mode_late;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_mode_wr |=> mode_reg == $past(mode_reg);
    endproperty
    a_mode_late: assert property (p_mode_late) else $error("mode applied at once");

    property p_mode_settle;
        @(posedge CLK_SYS) disable iff (!RSTN)
        s_mode_wr ##1 s_quiet2 |=> mode_reg == $past(pend_reg);
    endproperty
    a_mode_settle: assert property (p_mode_settle) else $error("mode not applied");

    property p_toggle;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf && omode_reg == 2'h1 |=> out_reg != $past(out_reg);
    endproperty
    a_toggle: assert property (p_toggle) else $error("output did not toggle");

    property p_low;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf && omode_reg == 2'h2 |=> !out_reg;
    endproperty
    a_low: assert property (p_low) else $error("output not forced low");

    property p_high;
        @(posedge CLK_SYS) disable iff (!RSTN)
        ovf && omode_reg == 2'h3 |=> out_reg;
    endproperty
    a_high: assert property (p_high) else $error("output not forced high");

    property p_hi_load;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_hi |=> count_reg == {$past(wnib), $past(rl_lo_reg)};
    endproperty
    a_hi_load: assert property (p_hi_load) else $error("upper write did not load");

    property p_lo_hold;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_lo && !tick |=> $stable(count_reg);
    endproperty
    a_lo_hold: assert property (p_lo_hold) else $error("lower write moved count");

    property p_latch;
        @(posedge CLK_SYS) disable iff (!RSTN)
        rd_hi |=> lat_lo_reg == $past(count_reg[3:0])
              && AVS_READDATA[3:0] == $past(count_reg[7:4]);
    endproperty
    a_latch: assert property (p_latch) else $error("upper read not coherent");

    property p_out_sel;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_omode |=> TIMER_OUTPUT_SEL == ($past(wnib[1:0]) != 2'h0);
    endproperty
    a_out_sel: assert property (p_out_sel) else $error("pin select wrong");

    property p_flag_hold;
        @(posedge CLK_SYS) disable iff (!RSTN)
        flag_reg && !(wr_stat && wnib[rtb_pkg::POS_OVF_FLAG]) |=> flag_reg;
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("overflow flag dropped");

    property p_ev_count;
        @(posedge CLK_SYS) disable iff (!RSTN)
        mode_reg.clk_sel == rtb_pkg::CSEL_EXT && pinfn_reg[0] && ev_fall |-> tick;
    endproperty
    a_ev_count: assert property (p_ev_count) else $error("event edge missed");

    property p_out_still;
        @(posedge CLK_SYS) disable iff (!RSTN)
        !ovf |=> out_reg == $past(out_reg);
    endproperty
    a_out_still: assert property (p_out_still) else $error("output moved early");

    property p_lo_store;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_lo |=> rl_lo_reg == $past(wnib);
    endproperty
    a_lo_store: assert property (p_lo_store) else $error("low nibble not stored");

    property p_pin_fn;
        @(posedge CLK_SYS) disable iff (!RSTN)
        wr_pinfn |=> PIN_FUNCTION == $past(wnib);
    endproperty
    a_pin_fn: assert property (p_pin_fn) else $error("pin function not stored");
endmodule
`default_nettype wire

/* verilog/rtb_pkg.sv */
// rtb_pkg: constants and types shared by the reload timer block
// assumes one 40 MHz system clock and a word-indexed avalon register map
package rtb_pkg;

    // register indices, byte address = 4 * index
    localparam logic [5:0] IDX_IRQ_STATUS = 6'h02;
    localparam logic [5:0] IDX_MODE_ONE   = 6'h09;
    localparam logic [5:0] IDX_RELOAD_LO  = 6'h0A;
    localparam logic [5:0] IDX_RELOAD_HI  = 6'h0B;
    localparam logic [5:0] IDX_OUT_MODE   = 6'h13;
    localparam logic [5:0] IDX_PIN_FN     = 6'h25;
    localparam logic [5:0] IDX_IRQ_MASK   = 6'h30;

    // field positions
    localparam int POS_RELOAD   = 3;
    localparam int POS_OVF_FLAG = 0;
    localparam int POS_EV_PIN   = 0;

    // reset values
    localparam logic [3:0] RST_MODE_ONE  = 4'h0;
    localparam logic [3:0] RST_RELOAD_LO = 4'h0;
    localparam logic [1:0] RST_OUT_MODE  = 2'h0;
    localparam logic [3:0] RST_PIN_FN    = 4'h0;
    localparam logic [7:0] RST_COUNT     = 8'h00;

    // counter limits
    localparam logic [7:0] CNT_TOP  = 8'hFF;
    localparam logic [7:0] CNT_WRAP = 8'h00;

    // clock select codes and prescaler tap widths (period = 2**width)
    localparam logic [2:0] CSEL_EXT  = 3'h7;
    localparam logic [3:0] TAP_2048  = 4'hB;
    localparam logic [3:0] TAP_512   = 4'h9;
    localparam logic [3:0] TAP_128   = 4'h7;
    localparam logic [3:0] TAP_32    = 4'h5;
    localparam logic [3:0] TAP_8     = 4'h3;
    localparam logic [3:0] TAP_4     = 4'h2;
    localparam logic [3:0] TAP_2     = 4'h1;
    localparam int         PRESC_W   = 11;

    // output modes
    localparam logic [1:0] OMODE_PORT   = 2'h0;
    localparam logic [1:0] OMODE_TOGGLE = 2'h1;
    localparam logic [1:0] OMODE_LOW    = 2'h2;
    localparam logic [1:0] OMODE_HIGH   = 2'h3;

    // a mode write settles two instruction cycles after the previous one
    localparam logic [1:0] MODE_SETTLE_CYC = 2'h2;

    typedef struct packed {
        logic       reload;
        logic [2:0] clk_sel;
    } rtb_mode_s;

endpackage

/* verilog/rtb_prescale.sv */
// rtb_prescale: free-running divider giving a one-cycle tap pulse
// assumes the tap code is stable or changes only at settle points
`timescale 1ns/100ps
`default_nettype none
module rtb_prescale (
    input  wire logic       clk_sys,
    input  wire logic       rstn,
    input  wire logic [2:0] clk_sel,
    output logic            tick
);
    logic [rtb_pkg::PRESC_W-1:0] div_reg;
    logic [3:0]                  tap_w;
    logic [rtb_pkg::PRESC_W-1:0] tap_mask;

    function automatic logic [3:0] tap_of(input logic [2:0] s);
        case (s)
            3'h0:    tap_of = rtb_pkg::TAP_2048;
            3'h1:    tap_of = rtb_pkg::TAP_512;
            3'h2:    tap_of = rtb_pkg::TAP_128;
            3'h3:    tap_of = rtb_pkg::TAP_32;
            3'h4:    tap_of = rtb_pkg::TAP_8;
            3'h5:    tap_of = rtb_pkg::TAP_4;
            default: tap_of = rtb_pkg::TAP_2;
        endcase
    endfunction

    assign tap_w    = tap_of(clk_sel);
    assign tap_mask = ~({rtb_pkg::PRESC_W{1'b1}} << tap_w);
    // pulse once per period when the low bits are all ones
    assign tick     = ((div_reg & tap_mask) == tap_mask);

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

/* verilog/rtb_fall_det.sv */
// rtb_fall_det: two-stage synchroniser and falling edge pulse
// assumes pulses on the pin last at least two system clocks
`timescale 1ns/100ps
`default_nettype none
module rtb_fall_det (
    input  wire logic clk_sys,
    input  wire logic rstn,
    input  wire logic pin,
    output logic      fall
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // only s2 and s3 feed the edge gate
    assign fall = s3_reg & ~s2_reg;

    always_ff @(posedge clk_sys) begin
        if (!rstn) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
endmodule
`default_nettype wire

/* test/rtb_event_src.sv */
// rtb_event_src: model of the source that drives the event input pin
// assumes the bench calls pulse() from its own clocked sequence
`timescale 1ns/100ps
`default_nettype none
module rtb_event_src (
    input  wire logic clk,
    output logic      pin
);
    // idle high, as a pulled-up input pin would sit
    initial pin = 1'b1;
    // four clocks low, four high: longer than the synchroniser needs
    task automatic pulse(input int n);
        for (int i = 0; i < n; i++) begin
            repeat (4) @(posedge clk);
            pin <= 1'b0;
            repeat (4) @(posedge clk);
            pin <= 1'b1;
        end
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* test/rtb_timer_tb.sv */
// rtb_timer_tb: self-checking bench for the reload timer block
// assumes an avalon-mm slave with waitrequest, clocked by the system clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, e, g); end end
module rtb_timer_tb;
    logic        clk_sys = 1'b0;
    logic        rstn;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ev_pin;
    logic        out_pin;
    logic        out_sel;
    logic [3:0]  pin_fn;
    logic        irq;
    int          bad_count = 0;
    int          n_checks = 0;
    logic [31:0] q;
    logic [7:0]  c;

    always #12.5 clk_sys = ~clk_sys;

    rtb_timer u_dut (
        .CLK_SYS         (clk_sys),
        .RSTN            (rstn),
        .AVS_ADDRESS     (avs_address),
        .AVS_READ        (avs_read),
        .AVS_WRITE       (avs_write),
        .AVS_WRITEDATA   (avs_writedata),
        .AVS_BYTEENABLE  (avs_byteenable),
        .AVS_READDATA    (avs_readdata),
        .AVS_WAITREQUEST (avs_waitrequest),
        .EVENT_INPUT_PIN (ev_pin),
        .TIMER_OUTPUT_PIN(out_pin),
        .TIMER_OUTPUT_SEL(out_sel),
        .PIN_FUNCTION    (pin_fn),
        .IRQ             (irq)
    );

    rtb_event_src u_src (
        .clk(clk_sys),
        .pin(ev_pin)
    );

    task automatic bus_wr(input logic [5:0] idx, input logic [3:0] d, input logic [3:0] en);
        @(posedge clk_sys);
        avs_address    <= {idx, 2'b00};
        avs_writedata  <= {28'h0000000, d};
        avs_byteenable <= en;
        avs_write      <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [5:0] idx, input logic [3:0] d);
        bus_wr(idx, d, 4'hF);
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] r);
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read    <= 1'b1;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        r = avs_readdata;
        avs_read <= 1'b0;
    endtask

    // high nibble first, so the low nibble comes from the latch
    task automatic rd_count(output logic [7:0] v);
        rd(rtb_pkg::IDX_RELOAD_HI, q);
        v[7:4] = q[3:0];
        rd(rtb_pkg::IDX_RELOAD_LO, q);
        v[3:0] = q[3:0];
    endtask

    // extra clocks so the count is never set before the mode is active
    task automatic set_mode(input logic [3:0] m);
        wr(rtb_pkg::IDX_MODE_ONE, m);
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic load(input logic [7:0] v);
        wr(rtb_pkg::IDX_RELOAD_LO, v[3:0]);
        wr(rtb_pkg::IDX_RELOAD_HI, v[7:4]);
    endtask

    task automatic t_reset();
        rd(rtb_pkg::IDX_OUT_MODE, q);
        `CHK("out_mode", 32'h0, q)
        rd(rtb_pkg::IDX_MODE_ONE, q);
        `CHK("mode_one", 32'h0, q)
        rd(rtb_pkg::IDX_PIN_FN, q);
        `CHK("pin_fn_rd", 32'h0, q)
        rd(rtb_pkg::IDX_IRQ_STATUS, q);
        `CHK("status", 32'h0, q)
        rd(6'h3F, q);
        `CHK("unmapped", 32'h0, q)
        @(negedge clk_sys);
        `CHK("out_pin", 1'b0, out_pin)
        `CHK("out_sel", 1'b0, out_sel)
        `CHK("pin_fn", 4'h0, pin_fn)
        `CHK("irq", 1'b0, irq)
        $display("test reset done");
    endtask

    task automatic t_reload_regs();
        set_mode(4'h7);
        wr(rtb_pkg::IDX_RELOAD_HI, 4'h5);
        rd_count(c);
        `CHK("hi_only", 8'h50, c)
        wr(rtb_pkg::IDX_RELOAD_LO, 4'hA);
        rd_count(c);
        `CHK("lo_only", 8'h50, c)
        wr(rtb_pkg::IDX_RELOAD_HI, 4'hC);
        rd_count(c);
        `CHK("hi_load", 8'hCA, c)
        rd(rtb_pkg::IDX_RELOAD_HI, q);
        load(8'h35);
        rd(rtb_pkg::IDX_RELOAD_LO, q);
        `CHK("latched_lo", 32'hA, q)
        bus_wr(rtb_pkg::IDX_PIN_FN, 4'h1, 4'h0);
        @(negedge clk_sys);
        `CHK("be_ignored", 4'h0, pin_fn)
        $display("test reload registers done");
    endtask

    task automatic t_event_toggle();
        wr(rtb_pkg::IDX_PIN_FN, 4'hB);
        @(negedge clk_sys);
        `CHK("pin_fn_set", 4'hB, pin_fn)
        set_mode(4'hF);
        wr(rtb_pkg::IDX_OUT_MODE, {2'h0, rtb_pkg::OMODE_TOGGLE});
        rd(rtb_pkg::IDX_OUT_MODE, q);
        `CHK("out_mode_rw", 32'h1, q)
        `CHK("sel_on", 1'b1, out_sel)
        wr(rtb_pkg::IDX_IRQ_MASK, 4'h1);
        load(8'hFE);
        u_src.pulse(1);
        rd_count(c);
        `CHK("one_edge", 8'hFF, c)
        `CHK("no_ovf", 1'b0, irq)
        u_src.pulse(1);
        rd_count(c);
        `CHK("reload", 8'hFE, c)
        `CHK("irq_set", 1'b1, irq)
        `CHK("toggle_hi", 1'b1, out_pin)
        u_src.pulse(2);
        `CHK("toggle_lo", 1'b0, out_pin)
        $display("test event and toggle done");
    endtask

    task automatic t_irq();
        wr(rtb_pkg::IDX_IRQ_MASK, 4'h0);
        @(negedge clk_sys);
        `CHK("masked", 1'b0, irq)
        wr(rtb_pkg::IDX_IRQ_MASK, 4'h1);
        @(negedge clk_sys);
        `CHK("unmasked", 1'b1, irq)
        rd(rtb_pkg::IDX_IRQ_MASK, q);
        `CHK("mask_rd", 32'h1, q)
        wr(rtb_pkg::IDX_IRQ_STATUS, 4'h1);
        rd(rtb_pkg::IDX_IRQ_STATUS, q);
        `CHK("cleared", 32'h0, q)
        `CHK("irq_clr", 1'b0, irq)
        $display("test interrupt done");
    endtask

    task automatic t_force();
        wr(rtb_pkg::IDX_OUT_MODE, {2'h0, rtb_pkg::OMODE_HIGH});
        u_src.pulse(2);
        `CHK("force_hi", 1'b1, out_pin)
        wr(rtb_pkg::IDX_OUT_MODE, {2'h0, rtb_pkg::OMODE_LOW});
        u_src.pulse(2);
        `CHK("force_lo", 1'b0, out_pin)
        wr(rtb_pkg::IDX_OUT_MODE, {2'h0, rtb_pkg::OMODE_PORT});
        @(negedge clk_sys);
        `CHK("sel_off", 1'b0, out_sel)
        set_mode(4'h7);
        load(8'hFF);
        u_src.pulse(1);
        rd_count(c);
        `CHK("wrap", 8'h00, c)
        wr(rtb_pkg::IDX_IRQ_STATUS, 4'h1);
        $display("test output modes and wrap done");
    endtask

    // span of four periods plus bus slack, so one tick of tolerance
    task automatic t_rates();
        int per[7];
        per = '{2048, 512, 128, 32, 8, 4, 2};
        wr(rtb_pkg::IDX_PIN_FN, 4'h0);
        for (int k = 0; k < 7; k++) begin
            set_mode(k[3:0]);
            load(8'h00);
            repeat (4 * per[k]) @(posedge clk_sys);
            rd_count(c);
            `CHK("rate", 1'b1, (c >= 8'd3 && c <= 8'd5))
        end
        $display("test clock rates done");
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        rstn           <= 1'b0;
        avs_address    <= 8'h00;
        avs_read       <= 1'b0;
        avs_write      <= 1'b0;
        avs_writedata  <= 32'h00000000;
        avs_byteenable <= 4'hF;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        t_reset();
        t_reload_regs();
        t_event_toggle();
        t_irq();
        t_force();
        t_rates();
        wrap_up();
    end

    // the rate test dominates at about 11k clocks
    initial begin
        repeat (30000) @(posedge clk_sys);
        bad_count++;
        $display("watchdog expired");
        wrap_up();
    end
endmodule
`default_nettype wire
